// ==== core/aimr_pkg.sv ====
// constants for the alarm flag and mode register slice
// assumes an 8-bit host register bus on the symbol clock
package aimr_pkg;
	localparam int          AIMR_AW          = 8;
	localparam int          AIMR_DW          = 8;
	localparam int          AIMR_NFLAG       = 4;
	localparam int          AIMR_METER_W     = 16;
	localparam int          AIMR_LOCK_W      = 8;
	localparam int          AIMR_PATH_W      = 16;
	localparam int          AIMR_MAX_DELAY   = 7;
	// -------------------------------------------------------------
	// register offsets
	// -------------------------------------------------------------
	localparam logic [7:0]  AIMR_ADDR_FLAGS  = 8'h05;
	localparam logic [7:0]  AIMR_ADDR_QUAT   = 8'h06;
	localparam logic [7:0]  AIMR_ADDR_PHASE  = 8'h07;
	localparam logic [7:0]  AIMR_ADDR_LIN    = 8'h08;
	localparam logic [7:0]  AIMR_ADDR_NL     = 8'h09;
	// -------------------------------------------------------------
	// field positions
	// -------------------------------------------------------------
	localparam int          AIMR_FLG_SNR     = 0;
	localparam int          AIMR_FLG_LOW     = 1;
	localparam int          AIMR_FLG_HIGH    = 2;
	localparam int          AIMR_FLG_SYNC    = 3;
	localparam int          AIMR_Q_TPOL      = 4;
	localparam int          AIMR_Q_RPOL      = 3;
	localparam int          AIMR_Q_STAG      = 2;
	localparam int          AIMR_C_DCTAP     = 5;
	localparam int          AIMR_C_ADAPT     = 4;
	localparam int          AIMR_C_ZCOEF     = 3;
	localparam int          AIMR_C_ZOUT      = 2;
	localparam int          AIMR_N_NEG       = 7;
	localparam int          AIMR_N_GAIN      = 0;
	localparam int          AIMR_N_ADAPT     = 3;
	localparam int          AIMR_N_ZCOEF     = 2;
	localparam int          AIMR_N_ZOUT      = 1;
	// -------------------------------------------------------------
	// writable bits and reset values
	// -------------------------------------------------------------
	localparam logic [7:0]  AIMR_QUAT_MASK   = 8'h1F;
	localparam logic [7:0]  AIMR_PHASE_MASK  = 8'h0F;
	localparam logic [7:0]  AIMR_LIN_MASK    = 8'h3F;
	localparam logic [7:0]  AIMR_NL_MASK     = 8'hFF;
	localparam logic [7:0]  AIMR_RST_VAL     = 8'h00;
	localparam logic [7:0]  AIMR_RD_NONE     = 8'h00;
	// gain codes as shift amounts: 1, 4, 64, 512 and 1 or 8
	localparam logic [3:0]  AIMR_SH_G1       = 4'h0;
	localparam logic [3:0]  AIMR_SH_G4       = 4'h2;
	localparam logic [3:0]  AIMR_SH_G64      = 4'h6;
	localparam logic [3:0]  AIMR_SH_G512     = 4'h9;
	localparam logic [3:0]  AIMR_SH_G8       = 4'h3;
	typedef enum logic [1:0] {
		AIMR_PAR_MASTER,
		AIMR_PAR_SLAVE,
		AIMR_SER_MAG,
		AIMR_SER_SIGN
	} aimr_port_mode_t;
endpackage

// ==== core/aimr_flag_cell.sv ====
// one sticky alarm flag with deferred clear
// assumes the condition input is registered on the same clock
`timescale 1ns/10ps
module aimr_flag_cell
	import aimr_pkg::*;
(
	input  wire logic clk_in,      // symbol clock
	input  wire logic arst_n_in,   // async reset, active low
	input  wire logic cond_in,     // source condition present
	input  wire logic clr_wr_in,   // host wrote zero to this flag
	output logic      flag_out,    // sticky flag
	output logic      pend_out     // clear waits for condition end
);
	typedef struct packed {
		logic flag;
		logic pend;
	} aimr_cell_t;
	aimr_cell_t st;
	aimr_cell_t next_st;

	always_comb begin
		next_st = st;
		// set wins over any clear in the same cycle
		next_st.flag = cond_in | (st.flag & ~clr_wr_in & ~st.pend);
		next_st.pend = cond_in & (st.pend | clr_wr_in);
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign flag_out = st.flag;
	assign pend_out = st.pend;

	property p_cell_hold;
		@(posedge clk_in) disable iff (!arst_n_in)
		(st.flag && !clr_wr_in && !st.pend) |=> st.flag;
	endproperty
	a_cell_hold: assert property (p_cell_hold)
		else $error("flag dropped without a clear");

	property p_cell_defer;
		@(posedge clk_in) disable iff (!arst_n_in)
		(clr_wr_in && cond_in) |=> (st.flag && st.pend);
	endproperty
	a_cell_defer: assert property (p_cell_defer)
		else $error("clear while condition held was not deferred");
endmodule // aimr_flag_cell

// ==== core/aimr_quat_port.sv ====
// quat port timing: baud clock edge picking and mode decode
// assumes baud clock pins are asynchronous and much slower than clk_in
`timescale 1ns/10ps
module aimr_quat_port
	import aimr_pkg::*;
(
	input  wire logic       clk_in,         // symbol clock
	input  wire logic       arst_n_in,      // async reset, active low
	input  wire logic [7:0] modes_in,       // quat port modes register
	input  wire logic       tx_baud_in,     // tx baud clock pin
	input  wire logic       rx_baud_in,     // rx baud clock pin
	output logic            tx_sample_out,  // take tx_quat_pair now
	output logic            rx_update_out,  // change rx_quat_pair now
	output logic            stagger_out,    // force fifo pointers
	output logic            par_master_out, // parallel, own clock
	output logic            par_slave_out,  // parallel, baud clocks
	output logic            serial_out,     // serial lines
	output logic            sign_first_out  // serial, sign bit first
);
	typedef struct packed {
		logic [1:0] t_sync;
		logic [1:0] r_sync;
		logic       t_prev;
		logic       r_prev;
		logic       t_stb;
		logic       r_stb;
	} aimr_qp_t;
	aimr_qp_t st;
	aimr_qp_t next_st;
	aimr_port_mode_t mode;
	logic t_edge;
	logic r_edge;

	assign mode = aimr_port_mode_t'(modes_in[1:0]);

	always_comb begin
		next_st = st;
		next_st.t_sync = {st.t_sync[0], tx_baud_in};
		next_st.r_sync = {st.r_sync[0], rx_baud_in};
		next_st.t_prev = st.t_sync[1];
		next_st.r_prev = st.r_sync[1];
		next_st.t_stb  = t_edge & (mode == AIMR_PAR_SLAVE);
		next_st.r_stb  = r_edge & (mode == AIMR_PAR_SLAVE);
	end

	// polarity one picks the falling edge, zero the rising edge
	assign t_edge = modes_in[AIMR_Q_TPOL] ?
		(st.t_prev & ~st.t_sync[1]) : (~st.t_prev & st.t_sync[1]);
	assign r_edge = modes_in[AIMR_Q_RPOL] ?
		(st.r_prev & ~st.r_sync[1]) : (~st.r_prev & st.r_sync[1]);

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign tx_sample_out  = st.t_stb;
	assign rx_update_out  = st.r_stb;
	// stagger only means something with slave baud clocks
	assign stagger_out    = modes_in[AIMR_Q_STAG] &
		(mode == AIMR_PAR_SLAVE);
	assign par_master_out = (mode == AIMR_PAR_MASTER);
	assign par_slave_out  = (mode == AIMR_PAR_SLAVE);
	assign serial_out     = (mode == AIMR_SER_MAG) |
		(mode == AIMR_SER_SIGN);
	assign sign_first_out = (mode == AIMR_SER_SIGN);

	property p_qp_slave_only;
		@(posedge clk_in) disable iff (!arst_n_in)
		(tx_sample_out || rx_update_out) |-> $past(par_slave_out);
	endproperty
	a_qp_slave_only: assert property (p_qp_slave_only)
		else $error("baud strobe outside parallel slave mode");
endmodule // aimr_quat_port

// ==== core/aimr_top.sv ====
// alarm flag and mode register slice of the transceiver register bank
// assumes a host bus already synchronous to clk_in and single-cycle
// read and write strobes; meters and thresholds come from logic on clk_in
// Contract
// - each flag sets on a valid source condition, stays set until cleared
// - writing zero clears a flag at once when its condition has ended
// - writing zero while condition holds: flag stays, clears when it ends
// - interrupt goes active on unmasked flag, inactive when none remain
// - mask one hides a flag; unmasking an active flag raises interrupt
// - sync flag: detector enabled and match count above lock threshold
// - high alarm: far-end meter strictly above high threshold
// - low alarm: far-end meter strictly below low threshold
// - noise alarm: ratio meter strictly above its threshold
// - slave mode tx quats sampled on baud edge picked by bit 4
// - slave mode rx quats change on baud edge picked by bit 3
// - slave mode bit 2 forces fifo pointers to staggered position
// - mode 00 parallel on own clock, 01 parallel on baud clocks
// - modes 10, 11 serial; 10 magnitude first, 11 sign first
// - phase field delays adc sample by sixteenths of a symbol period
// - bit 5 feeds plus one into last tap, else oldest tx sample
// - adapt bit enables coefficient updates, clear freezes them
// - clear bit holds all coefficients at zero while set
// - blanking bit zeros echo replica, adaptation keeps running
// - linear gain code selects 1, 4, 64 or 512
// - nonlinear adapt, clear and blank bits act like linear ones
// - nonlinear delay field inserts that many symbol delays
// - nonlinear gain bit makes gain eight times higher
// - negate bit clear passes canceller output unaltered
`timescale 1ns/10ps
module aimr_top
	import aimr_pkg::*;
#(
	parameter int METER_W = AIMR_METER_W,
	parameter int LOCK_W  = AIMR_LOCK_W,
	parameter int PATH_W  = AIMR_PATH_W
) (
	input  wire logic              clk_in,          // symbol clock
	input  wire logic              arst_n_in,       // async reset, low
	input  wire logic [AIMR_AW-1:0] addr_in,        // register address
	input  wire logic [AIMR_DW-1:0] wdata_in,       // write data
	input  wire logic              wr_in,           // write strobe
	input  wire logic              rd_in,           // read strobe
	output logic [AIMR_DW-1:0]     rdata_out,       // read data
	input  wire logic [3:0]        mask_in,         // flag masks, 1 hides
	output logic                   irq_n_out,       // interrupt, low
	input  wire logic              sync_en_in,      // sync detector on
	input  wire logic [LOCK_W-1:0] sync_count_in,   // match count
	input  wire logic [LOCK_W-1:0] lock_count_threshold_in, // sync limit
	input  wire logic [METER_W-1:0] fe_meter_in,    // far-end level
	input  wire logic [METER_W-1:0] fe_high_th_in,  // high threshold
	input  wire logic [METER_W-1:0] fe_low_th_in,   // low threshold
	input  wire logic [METER_W-1:0] snr_meter_in,   // noise meter
	input  wire logic [METER_W-1:0] snr_th_in,      // noise threshold
	input  wire logic              tx_baud_in,      // tx baud clock pin
	input  wire logic              rx_baud_in,      // rx baud clock pin
	output logic                   tx_sample_out,   // take tx quat
	output logic                   rx_update_out,   // update rx quat
	output logic                   fifo_stagger_out, // stagger pointers
	output logic                   par_master_out,  // mode 00
	output logic                   par_slave_out,   // mode 01
	output logic                   serial_out,      // modes 10, 11
	output logic                   sign_first_out,  // mode 11
	output logic [3:0]             adc_phase_out,   // sixteenths delay
	input  wire logic [PATH_W-1:0] oldest_tx_in,    // oldest tx sample
	output logic [PATH_W-1:0]      last_tap_out,    // linear last tap
	output logic                   lin_update_out,  // linear adapt on
	output logic                   lin_clear_out,   // linear coefs zero
	input  wire logic [PATH_W-1:0] lin_replica_in,  // linear replica
	output logic [PATH_W-1:0]      lin_replica_out, // gated replica
	output logic [3:0]             lin_gain_sh_out, // linear gain shift
	output logic                   nl_update_out,   // nonlinear adapt on
	output logic                   nl_clear_out,    // nonlinear zero
	input  wire logic [PATH_W-1:0] nl_replica_in,   // nonlinear replica
	output logic [PATH_W-1:0]      nl_replica_out,  // gated replica
	output logic [3:0]             nl_gain_sh_out,  // nonlinear shift
	input  wire logic [1:0]        tx_symbol_in,    // tx symbol
	input  wire logic              tx_symbol_vld_in, // symbol strobe
	output logic [1:0]             nl_symbol_out,   // delayed symbol
	input  wire logic [PATH_W-1:0] nl_path_in,      // path after canceller
	output logic [PATH_W-1:0]      nl_path_out      // optionally negated
);
	// -------------------------------------------------------------
	// state
	// -------------------------------------------------------------
	typedef struct packed {
		logic [7:0]                   quat;
		logic [7:0]                   phase;
		logic [7:0]                   lin;
		logic [7:0]                   nl;
		logic [3:0]                   cond;
		logic [7:0]                   rdata;
		logic [AIMR_MAX_DELAY-1:0][1:0] line;
		logic [1:0]                   sym;
		logic [PATH_W-1:0]            tap;
		logic [PATH_W-1:0]            lrep;
		logic [PATH_W-1:0]            nrep;
		logic [PATH_W-1:0]            path;
	} aimr_state_t;
	aimr_state_t st;
	aimr_state_t next_st;

	logic [3:0] flags;
	logic [3:0] pend;
	logic [3:0] clr_wr;
	logic       wr_flags;

	// -------------------------------------------------------------
	// helpers
	// -------------------------------------------------------------
	function automatic logic hit(input logic [7:0] a,
		input logic [7:0] want);
		hit = (a == want);
	endfunction

	function automatic logic [7:0] merge(input logic [7:0] data,
		input logic [7:0] wmask);
		merge = data & wmask;
	endfunction

	function automatic logic [3:0] lin_gain(input logic [1:0] code);
		case (code)
			2'h0:    lin_gain = AIMR_SH_G1;
			2'h1:    lin_gain = AIMR_SH_G4;
			2'h2:    lin_gain = AIMR_SH_G64;
			default: lin_gain = AIMR_SH_G512;
		endcase
	endfunction

	// a set clear bit overrides adapt so coefficients stay at zero
	function automatic logic upd(input logic [7:0] r);
		upd = r[AIMR_C_ADAPT] & ~r[AIMR_C_ZCOEF];
	endfunction

	assign wr_flags = wr_in & hit(addr_in, AIMR_ADDR_FLAGS);
	assign clr_wr   = {4{wr_flags}} & ~wdata_in[3:0];

	// -------------------------------------------------------------
	// next state
	// -------------------------------------------------------------
	always_comb begin
		next_st = st;
		if (wr_in) begin
			if (hit(addr_in, AIMR_ADDR_QUAT)) begin
				next_st.quat = merge(wdata_in, AIMR_QUAT_MASK);
			end
			if (hit(addr_in, AIMR_ADDR_PHASE)) begin
				next_st.phase = merge(wdata_in, AIMR_PHASE_MASK);
			end
			if (hit(addr_in, AIMR_ADDR_LIN)) begin
				next_st.lin = merge(wdata_in, AIMR_LIN_MASK);
			end
			if (hit(addr_in, AIMR_ADDR_NL)) begin
				next_st.nl = merge(wdata_in, AIMR_NL_MASK);
			end
		end
		// conditions are registered so the flag cells see clean levels
		next_st.cond[AIMR_FLG_SYNC] = sync_en_in &
			(sync_count_in > lock_count_threshold_in);
		next_st.cond[AIMR_FLG_HIGH] = fe_meter_in > fe_high_th_in;
		next_st.cond[AIMR_FLG_LOW]  = fe_meter_in < fe_low_th_in;
		next_st.cond[AIMR_FLG_SNR]  = snr_meter_in > snr_th_in;
		if (rd_in) begin
			case (addr_in)
				AIMR_ADDR_FLAGS: next_st.rdata = {4'h0, flags};
				AIMR_ADDR_QUAT:  next_st.rdata = st.quat;
				AIMR_ADDR_PHASE: next_st.rdata = st.phase;
				AIMR_ADDR_LIN:   next_st.rdata = st.lin;
				AIMR_ADDR_NL:    next_st.rdata = st.nl;
				default:         next_st.rdata = AIMR_RD_NONE;
			endcase
		end
		if (tx_symbol_vld_in) begin
			next_st.line = {st.line[AIMR_MAX_DELAY-2:0], tx_symbol_in};
		end
		// delay zero takes the current symbol straight through
		if (st.nl[6:4] == 3'h0) begin
			next_st.sym = tx_symbol_in;
		end else begin
			next_st.sym = st.line[st.nl[6:4] - 3'h1];
		end
		next_st.tap = st.lin[AIMR_C_DCTAP] ?
			PATH_W'(1) : oldest_tx_in;
		next_st.lrep = st.lin[AIMR_C_ZOUT] ?
			'0 : lin_replica_in;
		next_st.nrep = st.nl[AIMR_N_ZOUT] ?
			'0 : nl_replica_in;
		next_st.path = st.nl[AIMR_N_NEG] ?
			(~nl_path_in + PATH_W'(1)) : nl_path_in;
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			st       <= '0;
			st.quat  <= AIMR_RST_VAL;
			st.phase <= AIMR_RST_VAL;
			st.lin   <= AIMR_RST_VAL;
			st.nl    <= AIMR_RST_VAL;
		end else begin
			st <= next_st;
		end
	end

	// -------------------------------------------------------------
	// alarm flags
	// -------------------------------------------------------------
	for (genvar i = 0; i < AIMR_NFLAG; i++) begin : g_flag
		aimr_flag_cell u_cell (
			.clk_in    (clk_in),
			.arst_n_in (arst_n_in),
			.cond_in   (st.cond[i]),
			.clr_wr_in (clr_wr[i]),
			.flag_out  (flags[i]),
			.pend_out  (pend[i])
		);
	end

	// combinational so a mask change acts in the same cycle
	assign irq_n_out = ~|(flags & ~mask_in);

	// -------------------------------------------------------------
	// quat port
	// -------------------------------------------------------------
	aimr_quat_port u_port (
		.clk_in         (clk_in),
		.arst_n_in      (arst_n_in),
		.modes_in       (st.quat),
		.tx_baud_in     (tx_baud_in),
		.rx_baud_in     (rx_baud_in),
		.tx_sample_out  (tx_sample_out),
		.rx_update_out  (rx_update_out),
		.stagger_out    (fifo_stagger_out),
		.par_master_out (par_master_out),
		.par_slave_out  (par_slave_out),
		.serial_out     (serial_out),
		.sign_first_out (sign_first_out)
	);

	// -------------------------------------------------------------
	// outputs
	// -------------------------------------------------------------
	assign rdata_out       = st.rdata;
	assign adc_phase_out   = st.phase[3:0];
	assign last_tap_out    = st.tap;
	assign lin_update_out  = upd(st.lin);
	assign lin_clear_out   = st.lin[AIMR_C_ZCOEF];
	assign lin_replica_out = st.lrep;
	assign lin_gain_sh_out = lin_gain(st.lin[1:0]);
	// nonlinear control bits sit one place lower than the linear ones
	assign nl_update_out   = st.nl[AIMR_N_ADAPT] &
		~st.nl[AIMR_N_ZCOEF];
	assign nl_clear_out    = st.nl[AIMR_N_ZCOEF];
	assign nl_replica_out  = st.nrep;
	assign nl_gain_sh_out  = st.nl[AIMR_N_GAIN] ?
		AIMR_SH_G8 : AIMR_SH_G1;
	assign nl_symbol_out   = st.sym;
	assign nl_path_out     = st.path;

	// -------------------------------------------------------------
	// checks
	// -------------------------------------------------------------
	property p_set;
		@(posedge clk_in) disable iff (!arst_n_in)
		st.cond[AIMR_FLG_HIGH] |=> flags[AIMR_FLG_HIGH];
	endproperty
	a_set: assert property (p_set)
		else $error("high alarm flag not set");

	property p_clear_now;
		@(posedge clk_in) disable iff (!arst_n_in)
		(clr_wr[0] && !st.cond[0] && !pend[0]) |=> !flags[0];
	endproperty
	a_clear_now: assert property (p_clear_now)
		else $error("flag not cleared on write zero");

	property p_clear_late;
		@(posedge clk_in) disable iff (!arst_n_in)
		(pend[1] && !st.cond[1]) |=> !flags[1];
	endproperty
	a_clear_late: assert property (p_clear_late)
		else $error("deferred clear did not happen");

	property p_irq;
		@(posedge clk_in) disable iff (!arst_n_in)
		(|(flags & ~mask_in)) == !irq_n_out;
	endproperty
	a_irq: assert property (p_irq)
		else $error("interrupt level wrong");

	property p_unmask;
		@(posedge clk_in) disable iff (!arst_n_in)
		(flags[0] && $fell(mask_in[0])) |-> !irq_n_out;
	endproperty
	a_unmask: assert property (p_unmask)
		else $error("unmask did not raise interrupt");

	property p_sync;
		@(posedge clk_in) disable iff (!arst_n_in)
		(sync_en_in && sync_count_in > lock_count_threshold_in)
			|=> ##1 flags[AIMR_FLG_SYNC];
	endproperty
	a_sync: assert property (p_sync)
		else $error("sync flag missing");

	property p_low;
		@(posedge clk_in) disable iff (!arst_n_in)
		(fe_meter_in < fe_low_th_in) |=> ##1 flags[AIMR_FLG_LOW];
	endproperty
	a_low: assert property (p_low)
		else $error("low alarm flag missing");

	property p_snr;
		@(posedge clk_in) disable iff (!arst_n_in)
		(snr_meter_in > snr_th_in) |=> ##1 flags[AIMR_FLG_SNR];
	endproperty
	a_snr: assert property (p_snr)
		else $error("noise alarm flag missing");

	property p_blank;
		@(posedge clk_in) disable iff (!arst_n_in)
		st.lin[AIMR_C_ZOUT] |=> (lin_replica_out == '0);
	endproperty
	a_blank: assert property (p_blank)
		else $error("replica not blanked");

	property p_nblank;
		@(posedge clk_in) disable iff (!arst_n_in)
		st.nl[AIMR_N_ZOUT] |=> (nl_replica_out == '0);
	endproperty
	a_nblank: assert property (p_nblank)
		else $error("nonlinear replica not blanked");

	property p_zcoef;
		@(posedge clk_in) disable iff (!arst_n_in)
		lin_clear_out |-> !lin_update_out;
	endproperty
	a_zcoef: assert property (p_zcoef)
		else $error("update while coefficients held at zero");

	property p_pass;
		@(posedge clk_in) disable iff (!arst_n_in)
		!st.nl[AIMR_N_NEG] |=> (nl_path_out == $past(nl_path_in));
	endproperty
	a_pass: assert property (p_pass)
		else $error("path altered with negate clear");
endmodule // aimr_top

// ==== verification/aimr_host_model.sv ====
// host processor model driving the register bus of the slice
// assumes single-cycle strobes and registered read data one cycle later
`timescale 1ns/10ps
module aimr_host_model (
	input  wire logic       clk_in,    // symbol clock
	input  wire logic [7:0] rdata_in,  // read data from slice
	output logic      [7:0] addr_out,  // register address
	output logic      [7:0] wdata_out, // write data
	output logic            wr_out,    // write strobe
	output logic            rd_out     // read strobe
);
	initial begin
		addr_out = 8'h00;
		wdata_out = 8'h00;
		wr_out = 1'b0;
		rd_out = 1'b0;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in);
		#1;
		addr_out = a;
		wdata_out = d;
		wr_out = 1'b1;
		@(posedge clk_in);
		#1;
		wr_out = 1'b0;
		wdata_out = ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_in);
		#1;
		addr_out = a;
		rd_out = 1'b1;
		@(posedge clk_in);
		#1;
		rd_out = 1'b0;
		d = rdata_in;
	endtask
	// set then clear once, only after the clocks have locked
	task automatic stagger(input logic [7:0] mode);
		wr(8'h06, mode | 8'h04);
		wr(8'h06, mode & 8'hFB);
	endtask
endmodule // aimr_host_model

// ==== verification/tb.sv ====
// self-checking bench for the alarm flag and mode register slice
// assumes the host model drives the bus and the bench drives meters
`timescale 1ns/10ps
module tb;
	import aimr_pkg::*;
	logic clk_in = 0, arst_n_in = 0, wr_in, rd_in, irq_n_out, sync_en_in = 0;
	logic [7:0] addr_in, wdata_in, rdata_out, d, sync_count_in = 8'h20;
	logic [7:0] lock_count_threshold_in = 8'h20;
	logic [15:0] fe_meter_in = 16'h0010, fe_high_th_in = 16'h0010;
	logic [15:0] fe_low_th_in = 16'h0010, snr_meter_in = 16'h0100;
	logic [15:0] snr_th_in = 16'h0100, oldest_tx_in = 16'h1234;
	logic [15:0] lin_replica_in = 16'h0F0F, nl_replica_in = 16'h00F0;
	logic [15:0] nl_path_in = 16'h0003, last_tap_out, lin_replica_out;
	logic [15:0] nl_replica_out, nl_path_out;
	logic [3:0] mask_in = 4'h0, adc_phase_out, lin_gain_sh_out, nl_gain_sh_out;
	logic tx_baud_in = 0, rx_baud_in = 0, tx_symbol_vld_in = 0;
	logic [1:0] tx_symbol_in = 2'h0, nl_symbol_out;
	logic tx_sample_out, rx_update_out, fifo_stagger_out, par_master_out;
	logic par_slave_out, serial_out, sign_first_out, lin_update_out;
	logic lin_clear_out, nl_update_out, nl_clear_out;
	int fails = 0, checked = 0;
	aimr_top uut (.clk_in, .arst_n_in, .addr_in, .wdata_in, .wr_in, .rd_in,
		.rdata_out, .mask_in, .irq_n_out, .sync_en_in, .sync_count_in,
		.lock_count_threshold_in, .fe_meter_in, .fe_high_th_in, .fe_low_th_in,
		.snr_meter_in, .snr_th_in, .tx_baud_in, .rx_baud_in, .tx_sample_out,
		.rx_update_out, .fifo_stagger_out, .par_master_out, .par_slave_out,
		.serial_out, .sign_first_out, .adc_phase_out, .oldest_tx_in,
		.last_tap_out, .lin_update_out, .lin_clear_out, .lin_replica_in,
		.lin_replica_out, .lin_gain_sh_out, .nl_update_out, .nl_clear_out,
		.nl_replica_in, .nl_replica_out, .nl_gain_sh_out, .tx_symbol_in,
		.tx_symbol_vld_in, .nl_symbol_out, .nl_path_in, .nl_path_out);
	aimr_host_model host (.clk_in, .rdata_in(rdata_out), .addr_out(addr_in),
		.wdata_out(wdata_in), .wr_out(wr_in), .rd_out(rd_in));
	initial begin
		forever #2.5 clk_in = ~clk_in;
	end
	task automatic chk(string n, logic [15:0] e, logic [15:0] g);
		checked++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic final_report;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	// boundary values: equal to the threshold means no alarm
	task automatic cond(int i, bit on);
		case (i)
			0: snr_meter_in = on ? 16'h0101 : 16'h0100;
			1: fe_low_th_in = on ? 16'h0011 : 16'h0010;
			2: fe_high_th_in = on ? 16'h000F : 16'h0010;
			default: begin
				sync_en_in = on;
				sync_count_in = on ? 8'h21 : 8'h20;
			end
		endcase
		repeat (4) @(posedge clk_in);
		#1;
	endtask
	task automatic t_flags;
		for (int i = 0; i < 4; i++) begin
			cond(i, 1);
			cond(i, 0);
			host.rd(8'h05, d);
			chk("sticky", 16'(1 << i), 16'(d));
			chk("irq on", 16'h0, 16'(irq_n_out));
			host.wr(8'h05, 8'(~(1 << i)));
			host.rd(8'h05, d);
			chk("clr gone", 16'h0, 16'(d));
			chk("irq off", 16'h1, 16'(irq_n_out));
			cond(i, 1);
			host.wr(8'h05, 8'h00);
			host.rd(8'h05, d);
			chk("clr held", 16'(1 << i), 16'(d));
			cond(i, 0);
			host.rd(8'h05, d);
			chk("auto clr", 16'h0, 16'(d));
		end
	endtask
	task automatic t_mask;
		mask_in = 4'h1;
		cond(0, 1);
		chk("masked", 16'h1, 16'(irq_n_out));
		mask_in = 4'hE;
		#1;
		chk("unmask", 16'h0, 16'(irq_n_out));
		cond(0, 0);
		host.wr(8'h05, 8'h00);
		mask_in = 4'h0;
	endtask
	task automatic t_regs;
		logic [7:0] exp_v [5] = '{8'h00, 8'h1F, 8'h0F, 8'h3F, 8'hFF};
		for (int a = 5; a < 11; a++) begin
			host.wr(8'(a), 8'hFF);
			host.rd(8'(a), d);
			chk("reg", 16'(a < 10 ? exp_v[a-5] : 8'h00), 16'(d));
		end
		chk("phase", 16'hF, 16'(adc_phase_out));
	endtask
	task automatic t_modes;
		logic [3:0] dec [4] = '{4'h8, 4'h4, 4'h2, 4'h3};
		for (int m = 0; m < 4; m++) begin
			host.wr(8'h06, 8'(m));
			chk("mode", 16'(dec[m]), 16'({par_master_out, par_slave_out,
				serial_out, sign_first_out}));
		end
		host.wr(8'h06, 8'h05);
		chk("stag on", 16'h1, 16'(fifo_stagger_out));
		host.stagger(8'h01);
		chk("stag off", 16'h0, 16'(fifo_stagger_out));
	endtask
	// both baud pins move together; strobe stands one cycle
	task automatic baud(logic [7:0] m, bit lvl, logic [1:0] e);
		host.wr(8'h06, m);
		tx_baud_in = lvl;
		rx_baud_in = lvl;
		repeat (3) @(posedge clk_in);
		#1;
		chk("strobe", 16'(e),
			16'({tx_sample_out, rx_update_out}));
		@(posedge clk_in);
		#1;
		chk("strobe end", 16'h0,
			16'({tx_sample_out, rx_update_out}));
	endtask
	task automatic t_baud;
		baud(8'h01, 1'b1, 2'h3);
		baud(8'h19, 1'b0, 2'h3);
		baud(8'h11, 1'b1, 2'h1);
		baud(8'h11, 1'b0, 2'h2);
		baud(8'h03, 1'b1, 2'h0);
	endtask
	task automatic t_cancel;
		logic [3:0] sh [4] = '{4'h0, 4'h2, 4'h6, 4'h9};
		for (int g = 0; g < 4; g++) begin
			host.wr(8'h08, 8'(g) | 8'h10);
			chk("lgain", 16'(sh[g]), 16'(lin_gain_sh_out));
			chk("lupd", 16'h1, 16'(lin_update_out));
			@(posedge clk_in);
			#1;
			chk("ltap", 16'h1234, last_tap_out);
		end
		host.wr(8'h08, 8'h3C);
		chk("lclr", 16'h0, 16'({lin_update_out, ~lin_clear_out}));
		@(posedge clk_in);
		#1;
		chk("lrep", 16'h0, lin_replica_out);
		chk("ldc", 16'h1, last_tap_out);
		host.wr(8'h09, 8'h8B);
		chk("nupd", 16'h1, 16'(nl_update_out));
		chk("ngain", 16'h3, 16'(nl_gain_sh_out));
		@(posedge clk_in);
		#1;
		chk("nrep", 16'h0, nl_replica_out);
		chk("neg", 16'hFFFD, nl_path_out);
		host.wr(8'h09, 8'h04);
		chk("nclr", 16'h1, 16'(nl_clear_out));
		@(posedge clk_in);
		#1;
		chk("npass", 16'h0003, nl_path_out);
		host.wr(8'h09, 8'h20);
		for (int s = 1; s < 4; s++) begin
			tx_symbol_in = 2'(s);
			tx_symbol_vld_in = 1'b1;
			@(posedge clk_in);
			#1;
		end
		tx_symbol_vld_in = 1'b0;
		@(posedge clk_in);
		#1;
		chk("nsym", 16'h2, 16'(nl_symbol_out));
	endtask
	initial begin
		#20000;
		fails++;
		final_report;
	end
	initial begin
		repeat (5) @(posedge clk_in);
		#1;
		arst_n_in = 1;
		chk("rst irq", 16'h1, 16'(irq_n_out));
		chk("rst mode", 16'h1, 16'(par_master_out));
		t_flags;
		t_mask;
		t_regs;
		t_modes;
		t_baud;
		t_cancel;
		final_report;
	end
endmodule // tb
